// ### inc/tmr0_map.svh
// register indices, field positions and constant values of the timer block
`ifndef TMR0_MAP_SVH
`define TMR0_MAP_SVH
// word indices on the register bus; byte address is four times these
`define TMR0_IDX_CTRL 3'h0
`define TMR0_IDX_COUNT 3'h1
`define TMR0_IDX_CMP 3'h2
`define TMR0_IDX_FLAG 3'h3
`define TMR0_IDX_MASK 3'h4
// control register fields
`define TMR0_CS_HI 2
`define TMR0_CS_LO 0
`define TMR0_WGMH_BIT 3
`define TMR0_COM_HI 5
`define TMR0_COM_LO 4
`define TMR0_WGML_BIT 6
`define TMR0_FOC_BIT 7
// flag and mask register fields
`define TMR0_OVF_BIT 0
`define TMR0_CMP_BIT 1
// counter landmarks and reset values
`define TMR0_BOTTOM 8'h00
`define TMR0_MAX 8'hff
`define TMR0_ONE 8'h01
`define TMR0_RST_BYTE 8'h00
`define TMR0_RDATA_PAD 24'h000000
// clock source codes
`define TMR0_CS_STOP 3'h0
`define TMR0_CS_CLK 3'h1
`define TMR0_CS_D8 3'h2
`define TMR0_CS_D64 3'h3
`define TMR0_CS_D256 3'h4
`define TMR0_CS_D1024 3'h5
`define TMR0_CS_FALL 3'h6
`define TMR0_CS_RISE 3'h7
// compare output actions
`define TMR0_COM_OFF 2'h0
`define TMR0_COM_TOGGLE 2'h1
`define TMR0_COM_CLEAR 2'h2
`define TMR0_COM_SET 2'h3
`endif

// ### inc/tmr0_pkg.sv
// types shared by the timer block
package tmr0_pkg;
   // waveform modes, coded as the two mode bits {high, low}
   typedef enum logic [1:0] {
      TMR0_NORMAL = 2'h0,
      TMR0_PWM_PC = 2'h1,
      TMR0_CTC = 2'h2,
      TMR0_PWM_FAST = 2'h3
   } tmr0_mode_t;

   // whole state of the timer
   typedef struct packed {
      logic [2:0] cs;
      logic wgm_hi;
      logic wgm_lo;
      logic [1:0] com;
      logic [7:0] cnt;
      logic [7:0] ocr;
      logic [7:0] ocr_buf;
      logic down;
      logic ovf_f;
      logic cmp_f;
      logic ovf_ie;
      logic cmp_ie;
      logic block;
      logic oc;
      logic [2:0] sync;
      logic pin_lvl;
      logic ack;
      logic [7:0] rdata;
   } tmr0_state_t;
endpackage

// ### verilog/tmr0_counter.sv
// 8-bit timer/counter with one compare unit behind an avalon-mm slave
`timescale 1ns/100ps
`default_nettype none
`include "tmr0_map.svh"

// Operation
// - counter and compare value are both eight bits wide
// - bottom flags count 0x00, maximum flags count 0xff
// - top is 0xff or the compare value, depending on mode
// - ticks come from the clock, prescaler taps or the pin, with edge choice
// - clock source zero stops the timer, no ticks at all
// - each tick clears, increments or decrements the count by one
// - cpu may read and write the count at any time
// - a cpu count write beats clear or count in the same cycle
// - counting sequence follows the two waveform mode bits
// - overflow flag set per mode and usable as interrupt
// - equality sets the compare flag at the following tick
// - compare interrupt needs flag, enable and global enable
// - compare flag clears on interrupt service or write of one
// - match and max drive the waveform output
// - compare value double buffered in pwm modes only
// - buffered value moves to active compare at max
// - cpu compare access hits buffer or active register by mode
// - force strobe in non-pwm modes forces a match
// - forced match sets no flag, no clear, but updates output
// - flags sit in one flag register, each maskable
// - a count write blocks compare match on the next tick
// - normal mode counts up only and wraps max to zero
// - normal mode sets overflow in the tick the count hits zero
// - ctc mode clears the count when it matches compare value
module tmr0_counter (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [3:0] presc_tap_i,
   input wire logic external_count_pin_i,
   input wire logic global_int_en_i,
   input wire logic ovf_irq_ack_i,
   input wire logic cmp_irq_ack_i,
   output logic ovf_irq_o,
   output logic cmp_irq_o,
   output logic compare_output_o,
   output logic compare_output_en_o,
   output logic match_o,
   output logic max_o,
   output logic bottom_o
);

   // all state sits in one packed register; the rest is plain decode
   tmr0_pkg::tmr0_state_t s_q;
   tmr0_pkg::tmr0_state_t s_d;
   tmr0_pkg::tmr0_mode_t mode;
   logic pwm;
   logic pin_edge;
   logic tick;
   logic [7:0] top;
   logic top_hit;
   logic match;
   logic at_max;
   logic at_bottom;
   logic cmp_ev;
   logic force_ev;
   logic take;
   logic wr_ctrl;
   logic wr_count;
   logic wr_cmp;
   logic wr_flag;
   logic wr_mask;

   // the stop code yields no tick, so a stopped count moves only on writes
   // presc_tap_i bits: divide by 8, 64, 256, 1024 pulses
   function automatic logic tmr0_tick_sel(input logic [2:0] cs,
                                          input logic [3:0] taps,
                                          input logic edge_seen,
                                          input logic lvl);
      logic t;
      t = 1'b0;
      case (cs)
         `TMR0_CS_STOP: t = 1'b0;
         `TMR0_CS_CLK: t = 1'b1;
         `TMR0_CS_D8: t = taps[0];
         `TMR0_CS_D64: t = taps[1];
         `TMR0_CS_D256: t = taps[2];
         `TMR0_CS_D1024: t = taps[3];
         `TMR0_CS_FALL: t = edge_seen & ~lvl;
         `TMR0_CS_RISE: t = edge_seen & lvl;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // one register strobe, on the edge where the bus request is taken
   function automatic logic tmr0_hit(input logic [2:0] adr,
                                     input logic [2:0] idx,
                                     input logic be0);
      return (adr == idx) & be0;
   endfunction

   // mode decode and comparator
   assign mode = tmr0_pkg::tmr0_mode_t'({s_q.wgm_hi, s_q.wgm_lo});
   assign pwm = (mode == tmr0_pkg::TMR0_PWM_PC) |
                (mode == tmr0_pkg::TMR0_PWM_FAST);
   assign top = (mode == tmr0_pkg::TMR0_CTC) ? s_q.ocr : `TMR0_MAX;
   assign top_hit = (s_q.cnt == top);
   assign match = (s_q.cnt == s_q.ocr);
   assign at_max = (s_q.cnt == `TMR0_MAX);
   assign at_bottom = (s_q.cnt == `TMR0_BOTTOM);

   // pin edge only once second and third stages agree; first stage unread
   // the filtered level follows each edge, so a held pin ticks only once
   assign pin_edge = (s_q.sync[1] == s_q.sync[2]) &
                     (s_q.sync[2] != s_q.pin_lvl);
   assign tick = tmr0_tick_sel(s_q.cs, presc_tap_i, pin_edge,
                               s_q.sync[2]);

   // a match is seen at the tick after equality, unless a write blocks it
   assign cmp_ev = tick & match & ~s_q.block;

   // bus: one wait cycle, then the request is taken
   // the wait cycle lets read data come from a register; a write acts
   // only on the edge where waitrequest is seen low
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_q.ack;
   assign take = avs_write_i & s_q.ack;
   assign wr_ctrl = take & tmr0_hit(avs_address_i, `TMR0_IDX_CTRL,
                                    avs_byteenable_i[0]);
   assign wr_count = take & tmr0_hit(avs_address_i, `TMR0_IDX_COUNT,
                                     avs_byteenable_i[0]);
   assign wr_cmp = take & tmr0_hit(avs_address_i, `TMR0_IDX_CMP,
                                   avs_byteenable_i[0]);
   assign wr_flag = take & tmr0_hit(avs_address_i, `TMR0_IDX_FLAG,
                                    avs_byteenable_i[0]);
   assign wr_mask = take & tmr0_hit(avs_address_i, `TMR0_IDX_MASK,
                                    avs_byteenable_i[0]);
   assign force_ev = wr_ctrl & avs_writedata_i[`TMR0_FOC_BIT] & ~pwm;

   // next state
   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[1:0], external_count_pin_i};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.pin_lvl = s_q.sync[2];
      end
      // bus handshake and registered read data
      s_d.ack = (avs_read_i | avs_write_i) & ~s_q.ack;
      s_d.rdata = `TMR0_RST_BYTE;
      if (avs_read_i & ~s_q.ack) begin
         case (avs_address_i)
            `TMR0_IDX_CTRL: s_d.rdata = {1'b0, s_q.wgm_lo, s_q.com,
                                        s_q.wgm_hi, s_q.cs};
            `TMR0_IDX_COUNT: s_d.rdata = s_q.cnt;
            `TMR0_IDX_CMP: s_d.rdata = pwm ? s_q.ocr_buf : s_q.ocr;
            `TMR0_IDX_FLAG: s_d.rdata = {6'h00, s_q.cmp_f, s_q.ovf_f};
            `TMR0_IDX_MASK: s_d.rdata = {6'h00, s_q.cmp_ie, s_q.ovf_ie};
            default: s_d.rdata = `TMR0_RST_BYTE;
         endcase
      end
      // control fields; force bit is a strobe and is not stored
      if (wr_ctrl) begin
         s_d.cs = avs_writedata_i[`TMR0_CS_HI:`TMR0_CS_LO];
         s_d.wgm_hi = avs_writedata_i[`TMR0_WGMH_BIT];
         s_d.wgm_lo = avs_writedata_i[`TMR0_WGML_BIT];
         s_d.com = avs_writedata_i[`TMR0_COM_HI:`TMR0_COM_LO];
      end
      if (wr_mask) begin
         s_d.ovf_ie = avs_writedata_i[`TMR0_OVF_BIT];
         s_d.cmp_ie = avs_writedata_i[`TMR0_CMP_BIT];
      end
      // counter: cpu write first, then tick action per mode
      if (wr_count) begin
         s_d.cnt = avs_writedata_i[7:0];
      end else if (tick) begin
         case (mode)
            tmr0_pkg::TMR0_CTC: begin
               s_d.cnt = top_hit ? `TMR0_BOTTOM : s_q.cnt + `TMR0_ONE;
            end
            tmr0_pkg::TMR0_PWM_PC: begin
               // dual slope: turn round at max and at bottom
               if (s_q.down & at_bottom) begin
                  s_d.down = 1'b0;
                  s_d.cnt = s_q.cnt + `TMR0_ONE;
               end else if (~s_q.down & at_max) begin
                  s_d.down = 1'b1;
                  s_d.cnt = s_q.cnt - `TMR0_ONE;
               end else if (s_q.down) begin
                  s_d.cnt = s_q.cnt - `TMR0_ONE;
               end else begin
                  s_d.cnt = s_q.cnt + `TMR0_ONE;
               end
            end
            default: begin
               s_d.cnt = s_q.cnt + `TMR0_ONE;
            end
         endcase
      end
      if (mode != tmr0_pkg::TMR0_PWM_PC) begin
         s_d.down = 1'b0;
      end
      // count write arms the block, the next tick consumes it
      // a blocked tick still clears in ctc mode; only the match is held
      if (wr_count) begin
         s_d.block = 1'b1;
      end else if (tick) begin
         s_d.block = 1'b0;
      end
      // compare value: buffered in pwm, direct otherwise
      // pwm keeps the active value through a whole period, so no pulse
      // comes out odd-length; the copy waits for the wrap at max
      if (wr_cmp) begin
         s_d.ocr_buf = avs_writedata_i[7:0];
         if (~pwm) begin
            s_d.ocr = avs_writedata_i[7:0];
         end
      end else if (pwm & tick & at_max) begin
         s_d.ocr = s_q.ocr_buf;
      end
      // overflow flag: set wins over clear
      if (wr_flag & avs_writedata_i[`TMR0_OVF_BIT] | ovf_irq_ack_i) begin
         s_d.ovf_f = 1'b0;
      end
      if (tick & (mode == tmr0_pkg::TMR0_PWM_PC ? s_q.down & at_bottom
                                               : at_max)) begin
         s_d.ovf_f = 1'b1;
      end
      // compare flag: forced matches never reach it
      if (wr_flag & avs_writedata_i[`TMR0_CMP_BIT] | cmp_irq_ack_i) begin
         s_d.cmp_f = 1'b0;
      end
      if (cmp_ev) begin
         s_d.cmp_f = 1'b1;
      end
      // waveform output register
      // the output keeps its level across mode changes, so a forced match
      // can preset it before a change to a pwm mode; any stored action other than off already hands it the pin
      // a force uses the action already stored, not one written with it
      if (~pwm & (cmp_ev | force_ev)) begin
         case (s_q.com)
            `TMR0_COM_TOGGLE: s_d.oc = ~s_q.oc;
            `TMR0_COM_CLEAR: s_d.oc = 1'b0;
            `TMR0_COM_SET: s_d.oc = 1'b1;
            default: s_d.oc = s_q.oc;
         endcase
      end else if (pwm & s_q.com[1]) begin
         // bit 0 of the action inverts the pwm output
         if (cmp_ev) begin
            s_d.oc = (mode == tmr0_pkg::TMR0_PWM_PC & s_q.down) ^
                     s_q.com[0];
         end else if (mode == tmr0_pkg::TMR0_PWM_FAST & tick & at_max) begin
            s_d.oc = ~s_q.com[0];
         end
      end
   end

   // single state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs; the pin enable follows the action field in every mode
   assign avs_readdata_o = {`TMR0_RDATA_PAD, s_q.rdata};
   assign ovf_irq_o = s_q.ovf_f & s_q.ovf_ie & global_int_en_i;
   assign cmp_irq_o = s_q.cmp_f & s_q.cmp_ie & global_int_en_i;
   assign compare_output_o = s_q.oc;
   assign compare_output_en_o = (s_q.com != `TMR0_COM_OFF);
   assign match_o = match;
   assign max_o = at_max;
   assign bottom_o = at_bottom;

   // checks; they watch state the design drives, some against the bus stimulus
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   stop_no_tick_a: assert property (s_q.cs == `TMR0_CS_STOP |-> !tick)
      else $error("tick while stopped");
   cpu_wr_prio_a: assert property (wr_count |=>
      s_q.cnt == $past(avs_writedata_i[7:0]))
      else $error("count write lost");
   cmp_flag_set_a: assert property (cmp_ev |=> s_q.cmp_f)
      else $error("compare flag not set");
   wr_blocks_a: assert property (wr_count ##1 tick |-> !cmp_ev)
      else $error("match after count write");
   ctc_clear_a: assert property (mode == tmr0_pkg::TMR0_CTC && tick &&
      match && !wr_count |=> s_q.cnt == `TMR0_BOTTOM)
      else $error("ctc did not clear");
   normal_wrap_a: assert property (mode == tmr0_pkg::TMR0_NORMAL &&
      tick && at_max && !wr_count |=> s_q.cnt == `TMR0_BOTTOM && s_q.ovf_f)
      else $error("normal wrap wrong");
   force_noflag_a: assert property (force_ev && !cmp_ev && !s_q.cmp_f &&
      !tick |=> !s_q.cmp_f && s_q.cnt == $past(s_q.cnt))
      else $error("forced match touched flag");
   dbuf_hold_a: assert property (pwm && !(tick && at_max) &&
      $past(pwm) |=> s_q.ocr == $past(s_q.ocr))
      else $error("compare changed off top");
   cmp_irq_a: assert property ($rose(s_q.cmp_f) && s_q.cmp_ie &&
      global_int_en_i |-> cmp_irq_o)
      else $error("compare irq missing");

   // count path: stop holds, normal steps by one, dual slope turns round
   stop_hold_a: assert property (s_q.cs == `TMR0_CS_STOP &&
      !wr_count |=> s_q.cnt == $past(s_q.cnt))
      else $error("count moved while stopped");
   up_step_a: assert property (mode == tmr0_pkg::TMR0_NORMAL &&
      tick && !wr_count |=> s_q.cnt == $past(s_q.cnt) + `TMR0_ONE)
      else $error("normal step wrong");
   pc_turn_a: assert property (mode == tmr0_pkg::TMR0_PWM_PC &&
      tick && at_max && !s_q.down && !wr_count |=>
      s_q.down && s_q.cnt == `TMR0_MAX - `TMR0_ONE)
      else $error("dual slope did not turn at max");
   pc_ovf_a: assert property (mode == tmr0_pkg::TMR0_PWM_PC &&
      tick && s_q.down && at_bottom && !wr_count |=> s_q.ovf_f && !s_q.down)
      else $error("dual slope overflow missing");

   // flags, compare value and forced output
   cmp_clear_a: assert property (cmp_irq_ack_i && !cmp_ev |=>
      !s_q.cmp_f)
      else $error("compare flag not cleared");
   dbuf_off_a: assert property (wr_cmp && !pwm |=>
      s_q.ocr == $past(avs_writedata_i[7:0]))
      else $error("direct compare write lost");
   cmp_read_a: assert property (avs_read_i && !s_q.ack && pwm &&
      avs_address_i == `TMR0_IDX_CMP |=>
      avs_readdata_o[7:0] == $past(s_q.ocr_buf))
      else $error("compare read not from buffer");
   force_set_a: assert property (force_ev &&
      s_q.com == `TMR0_COM_SET |=> s_q.oc)
      else $error("forced set missing");

   // scenarios worth seeing at least once
   ctc_clear_c: cover property (mode == tmr0_pkg::TMR0_CTC && cmp_ev);
   force_c: cover property (force_ev ##1 s_q.oc != $past(s_q.oc));
   reload_c: cover property (pwm && tick && at_max && !wr_cmp);
   pc_bottom_c: cover property (mode == tmr0_pkg::TMR0_PWM_PC && tick &&
      s_q.down && at_bottom);
   pin_fall_c: cover property (s_q.cs == `TMR0_CS_FALL && tick);

endmodule
`default_nettype wire

// ### test/tmr0_far_model.sv
// prescaler taps and external count pin as seen by the timer
`timescale 1ns/100ps
`default_nettype none
module tmr0_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_run_i,
   output logic [3:0] presc_tap_o,
   output logic external_count_pin_o
);
   logic [9:0] div_q;
   // free divider; the pin only moves while a run is open
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_q <= 10'h000;
         external_count_pin_o <= 1'b0;
      end else begin
         div_q <= div_q + 10'h001;
         // slow toggling keeps every level wider than the synchroniser
         if (pin_run_i && div_q[1:0] == 2'h3) begin
            external_count_pin_o <= ~external_count_pin_o;
         end
      end
   end
   // one-cycle pulses at /8, /64, /256 and /1024
   assign presc_tap_o = {div_q == 10'h3ff, div_q[7:0] == 8'hff,
      div_q[5:0] == 6'h3f, div_q[2:0] == 3'h7};
endmodule
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the timer against an integer model
`timescale 1ns/100ps
`default_nettype none
`include "tmr0_map.svh"
module tb;
   localparam logic [2:0] ix_ctl = `TMR0_IDX_CTRL;
   localparam logic [2:0] ix_cnt = `TMR0_IDX_COUNT;
   localparam logic [2:0] ix_cmp = `TMR0_IDX_CMP;
   localparam logic [2:0] ix_flg = `TMR0_IDX_FLAG;
   logic clk_i, rst_i, rd, wr, gie, oack, cack, pin_run, gate, pin_p, pin;
   logic wq, oirq, cirq, oc, ocen, mt, mx, bt;
   logic [2:0] adr;
   logic [3:0] be, taps;
   logic [31:0] wdat, rdo, rdata;
   int miscompares, check_count, cyc, nt, seed, cs, k, c, m, st, v, t1, t2;
   int m_c, m_cmp, m_buf, m_of, m_cf, m_blk, m_mode, m_dn, mk, gi;

   tmr0_counter u_tmr0_counter (.clk_i(clk_i), .rst_i(rst_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_byteenable_i(be), .avs_writedata_i(wdat),
      .avs_readdata_o(rdo), .avs_waitrequest_o(wq), .presc_tap_i(taps),
      .external_count_pin_i(pin), .global_int_en_i(gie),
      .ovf_irq_ack_i(oack), .cmp_irq_ack_i(cack), .ovf_irq_o(oirq),
      .cmp_irq_o(cirq), .compare_output_o(oc), .compare_output_en_o(ocen),
      .match_o(mt), .max_o(mx), .bottom_o(bt));
   tmr0_far_model u_tmr0_far_model (.clk_i(clk_i), .rst_i(rst_i),
      .pin_run_i(pin_run), .presc_tap_o(taps), .external_count_pin_o(pin));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // reference tick count: source events while a run is open
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      pin_p <= pin;
      if (gate && (cs == 1 || (cs > 1 && cs < 6 && taps[cs-2]) ||
         (cs == 6 && pin_p && !pin) || (cs == 7 && !pin_p && pin))) begin
         nt <= nt + 1;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [2:0] a,
      input logic [7:0] d, output int stamp);
      @(posedge clk_i);
      adr <= a;
      wdat <= {24'h000000, d};
      rd <= ~w;
      wr <= w;
      // waitrequest and read data as they stand at the taking edge
      do @(posedge clk_i); while (wq);
      stamp = cyc;
      rdata = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   function automatic logic [7:0] ctl(input int src);
      ctl = {1'b0, 1'(m_mode), 2'h0, 1'(m_mode >> 1), 3'(src)};
   endfunction
   task automatic wc(input int val);
      bus(1'b1, ix_cnt, 8'(val), st);
      m_c = val;
      m_blk = 1;
   endtask
   task automatic wp(input int val);
      bus(1'b1, ix_cmp, 8'(val), st);
      m_buf = val;
      if (m_mode == 0 || m_mode == 2) m_cmp = val;
   endtask
   task automatic tick();
      if (m_c == m_cmp && m_blk == 0) m_cf = 1;
      if (m_c == 255 && m_mode != 1) m_of = 1;
      if (m_mode % 2 == 1 && m_c == 255) m_cmp = m_buf;
      if (m_mode == 1) begin
         if (m_c == 0 && m_dn == 1) m_of = 1;
         if (m_c == 0) m_dn = 0;
         if (m_c == 255) m_dn = 1;
         m_c = (m_dn == 1) ? m_c - 1 : m_c + 1;
      end else if (m_mode == 2 && m_c == m_cmp) m_c = 0;
      else m_c = (m_c + 1) % 256;
      m_blk = 0;
   endtask
   task automatic run(input int src, input int n);
      int nb;
      cs = src;
      bus(1'b1, ix_ctl, ctl(src), st);
      nb = nt;
      gate <= 1'b1;
      pin_run <= 1'b1;
      repeat (n) @(posedge clk_i);
      pin_run <= 1'b0;
      repeat (6) @(posedge clk_i);
      bus(1'b1, ix_ctl, ctl(0), st);
      gate <= 1'b0;
      @(negedge clk_i);
      for (int i = 0; i < nt - nb; i++) tick();
   endtask
   task automatic verify();
      bus(1'b0, ix_cnt, 8'h00, st);
      chk(rdata, 32'(m_c));
      bus(1'b0, ix_flg, 8'h00, st);
      chk(rdata, 32'(m_cf * 2 + m_of));
   endtask
   task automatic clr();
      bus(1'b1, ix_flg, 8'h03, st);
      m_of = 0;
      m_cf = 0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #5000000;
      miscompares++;
      summarize();
   end
   initial begin
      {rd, wr, gie, oack, cack, pin_run, gate} = 7'h00;
      {adr, be, wdat, cs, cyc, nt, miscompares, check_count} = '0;
      {m_c, m_cmp, m_buf, m_of, m_cf, m_blk, m_mode, m_dn} = '0;
      be = 4'hf;
      seed = 32'hd7df;
      rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, index 5 is unmapped
      @(negedge clk_i);
      chk({mx, bt, mt, oc, ocen}, 32'h0c);
      for (k = 0; k < 6; k++) begin
         bus(1'b0, 3'(k), 8'h00, st);
         chk(rdata, 32'h0);
      end
      $display("reset test done");
      // every clock source in normal and clear-on-compare modes
      mk = $unsigned($random(seed)) % 4;
      bus(1'b1, `TMR0_IDX_MASK, 8'(mk), st);
      for (m = 0; m < 3; m += 2) begin
         for (c = 0; c < 8; c++) begin
            m_mode = m;
            wp($unsigned($random(seed)) % 256);
            v = 240 + $unsigned($random(seed)) % 16;
            if (c == 1) v = m_cmp;
            wc(v);
            run(c, (c == 5) ? 2100 : 300 + $unsigned($random(seed)) % 32);
            verify();
            gi = $unsigned($random(seed)) % 2;
            gie <= 1'(gi);
            @(negedge clk_i);
            chk({cirq, oirq}, 32'((m_cf & (mk >> 1) & gi) * 2 +
               (m_of & mk & gi)));
            if (c % 2) begin
               @(posedge clk_i);
               oack <= 1'b1;
               cack <= 1'b1;
               @(posedge clk_i);
               oack <= 1'b0;
               cack <= 1'b0;
               m_of = 0;
               m_cf = 0;
            end else clr();
            verify();
         end
      end
      $display("source and mode test done");
      // a count write while running wins; normal mode keeps the sum exact
      m_mode = 0;
      bus(1'b1, ix_ctl, ctl(1), st);
      repeat (5) @(posedge clk_i);
      bus(1'b1, ix_cnt, 8'h40, t1);
      bus(1'b1, ix_ctl, ctl(0), t2);
      bus(1'b0, ix_cnt, 8'h00, st);
      chk(rdata, 32'h40 + 32'(t2 - t1));
      m_c = 64 + t2 - t1;
      clr();
      // ignored writes: no byte enable, unmapped index
      be <= 4'he;
      bus(1'b1, ix_cnt, 8'h55, st);
      be <= 4'hf;
      bus(1'b1, 3'h6, 8'h55, st);
      verify();
      $display("write priority test done");
      // compare value buffered only in pwm modes
      m_mode = 0;
      bus(1'b1, ix_ctl, ctl(0), st);
      wp(8'h10);
      wc(8'h10);
      @(negedge clk_i);
      chk(mt, 1);
      m_mode = 3;
      bus(1'b1, ix_ctl, ctl(0), st);
      wp(8'h20);
      bus(1'b0, ix_cmp, 8'h00, st);
      chk(rdata, 32'h20);
      @(negedge clk_i);
      chk(mt, 1);
      wc(8'hff);
      run(1, 4);
      verify();
      wc(8'h20);
      @(negedge clk_i);
      chk(mt, 1);
      clr();
      $display("buffer test done");
      // dual slope: up to max, down to bottom, overflow at the turn
      m_mode = 1;
      wc(8'hfc);
      run(1, 300 + $unsigned($random(seed)) % 32);
      verify();
      clr();
      $display("dual slope test done");
      // forced match: set, clear, toggle, with no flag or count change
      m_mode = 0;
      for (k = 3; k > 0; k--) begin
         // the force acts with the stored action, so store it first
         bus(1'b1, ix_ctl, 8'(k << 4), st);
         bus(1'b1, ix_ctl, 8'h80 | 8'(k << 4), st);
         bus(1'b0, ix_ctl, 8'h00, st);
         chk(rdata, 32'(k << 4));
         @(negedge clk_i);
         chk({ocen, oc}, {30'h0, 1'b1, 1'(k != 2)});
         verify();
      end
      $display("force test done");
      summarize();
   end
endmodule
`default_nettype wire
